// ### dv/rule_action_executor_tb.sv
// self-checking bench for the rule action executor
`timescale 1ns/1ps
`include "rae_map.svh"
module rule_action_executor_tb;
  localparam int DEPTH = 16;  // small rule table
  localparam int CDIV  = 20;  // short coarse tick
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, lag;
  logic        trig_valid, trig_ready, fire, accepted;
  logic [7:0]  trig_index, fire_index, pwm, v1, v2;
  logic [11:0] t_run, t_exp;
  // ***************************************
  // behavioural model state
  // ***************************************
  logic [7:0]  m_kind[DEPTH], m_par[DEPTH], m_nxt[DEPTH];
  logic [7:0]  m_v1, m_v2, m_duty, k, p;
  logic [11:0] m_run;
  bit          m_norm;
  int          compares, miscompares, cyc;

  rule_action_executor #(.DEPTH(DEPTH), .COARSE_DIV(CDIV))
    rule_action_executor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .trig_valid(trig_valid),
    .trig_index(trig_index), .trig_ready(trig_ready),
    .pwm_duty_setting(pwm), .var1_value(v1), .var2_value(v2),
    .timer_running(t_run), .timer_expired(t_exp));
  trigger_source trigger_source_i (.hclk(hclk), .hresetn(hresetn),
    .fire(fire), .fire_index(fire_index), .lag(lag),
    .trig_ready(trig_ready), .trig_valid(trig_valid),
    .trig_index(trig_index), .accepted(accepted));

  // ***************************************
  // clock, timeout and closing report
  // ***************************************
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end
  task automatic results;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // compare one value against the model
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // ***************************************
  // bus, table and trigger tasks
  // ***************************************
  task automatic bus(input bit wr, input logic [31:0] a, wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // one table entry, mirrored in the model
  task automatic put(input int i, input logic [7:0] kk, pp, nn);
    bus(1, 32'h400 + 4 * i, {8'h00, kk, pp, nn});
    m_kind[i] = kk;
    m_par[i]  = pp;
    m_nxt[i]  = nn;
  endtask
  // walk the model chain the way the rules order it
  task automatic run_model(input logic [7:0] idx);
    int n;
    n = 0;
    while (idx != 8'hFF && idx < DEPTH && n < 50) begin
      p = m_par[idx];
      case (m_kind[idx])
        `ACT_SET_DUTY: if (m_norm) m_duty = p;
        `ACT_SET_V1:   m_v1 = p;
        `ACT_SET_V2:   m_v2 = p;
        `ACT_TIMER: if (p[6:4] == 3'h0 && p[3:0] < 4'hC)
          m_run[p[3:0]] = p[7];
        `ACT_CHANGE: case (p)
          8'h00: m_v1 = m_v1 - 8'h01;
          8'h01: m_v1 = m_v1 + 8'h01;
          8'h02: m_v1 = m_v1 >> 1;
          8'h03: m_v1 = m_v1 << 1;
          // codes 4..11: second variable and duty, ungated
          8'h04: m_v2 = m_v2 - 8'h01;
          8'h05: m_v2 = m_v2 + 8'h01;
          8'h06: m_v2 = m_v2 >> 1;
          8'h07: m_v2 = m_v2 << 1;
          8'h08: m_duty = m_duty - 8'h01;
          8'h09: m_duty = m_duty + 8'h01;
          8'h0A: m_duty = m_duty >> 1;
          8'h0B: m_duty = m_duty << 1;
          8'h0C: m_v1 = m_v2;
          8'h0D: m_v2 = m_v1;
          8'h0E: m_v1 = m_duty;
          8'h0F: m_duty = m_v1;
          8'h10: m_v1 = m_v1 + m_v2;
          8'h11: m_v1 = m_v1 - m_v2;
          default: ;
        endcase
        default: ;
      endcase
      idx = m_nxt[idx];
      n++;
    end
  endtask
  // launch a chain, wait for the walker to go idle, compare
  task automatic go(input logic [7:0] idx);
    @(posedge hclk);
    fire       <= 1'b1;
    fire_index <= idx;
    lag        <= 2'($urandom_range(3, 0));
    @(posedge hclk);
    fire <= 1'b0;
    do @(posedge hclk); while (accepted !== 1'b1);
    do @(posedge hclk); while (trig_ready !== 1'b1);
    run_model(idx);
    chk({pwm, v1, v2, t_run}, {m_duty, m_v1, m_v2, m_run});
  endtask
  // wait for timer t to run out inside a window, expiry pulse seen
  task automatic expire(input int t, input int lo, input int hi);
    int  n;
    bit  seen;
    n = 0;
    seen = 0;
    while (t_run[t] === 1'b1 && n < hi) begin
      @(posedge hclk);
      seen = seen | t_exp[t];
      n++;
    end
    m_run[t] = 1'b0;
    chk({35'h0, seen && n >= lo && n < hi}, 36'h1);
    chk({24'h0, t_run}, {24'h0, m_run});
  endtask

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, fire, fire_index, lag} = '0;
    {m_v1, m_v2, m_duty, m_run} = '0;
    m_norm = 1;
    hresetn = 1'b0;
    void'($urandom(32'h0563d080));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk({pwm, v1, v2, t_run}, 36'h0);
    bus(0, 32'h20, 32'h0);
    chk({4'h0, rd}, 36'h0);
    bus(0, `OFF_FINE_LEN, 32'h0);
    chk({4'h0, rd}, {20'h0, `RST_FINE_LEN});
    bus(1, `OFF_FINE_LEN, 32'h2);
    bus(1, `OFF_COARSE_LEN, 32'h3);
    $display("test reset done");
    // random chains of four actions, normal mode off every third run
    for (int r = 0; r < 24; r++) begin
      m_norm = (r % 3 != 0);
      bus(1, `OFF_CTRL, {31'h0, m_norm});
      for (int i = 0; i < 4; i++) begin
        // types 100..106; the timer slot becomes set-variable-two
        k = 8'($urandom_range(106, 100));
        if (k == `ACT_TIMER) k = `ACT_SET_V2;
        if (i == 2 || $urandom_range(3, 0) == 0) k = `ACT_CHANGE;
        p = 8'($urandom_range(255, 0));
        if (k == `ACT_CHANGE && p[7]) p = 8'($urandom_range(17, 0));
        put(i, k, p,
          (i < 3) ? 8'(i + 1) : (r[0] ? 8'hFF : 8'(DEPTH + r)));
      end
      go(8'h00);
    end
    go(8'hFF);
    bus(1, `OFF_CTRL, 32'h1);
    m_norm = 1;
    $display("test chains done");
    // start, cancel and reserved timer codes in one chain
    put(0, `ACT_TIMER, 8'h80, 8'h01);
    put(1, `ACT_TIMER, 8'h89, 8'h02);
    put(2, `ACT_TIMER, 8'h00, 8'h03);
    put(3, `ACT_TIMER, 8'h8C, 8'h04);
    put(4, `ACT_TIMER, 8'h90, 8'hFF);
    go(8'h00);
    expire(9, 2 * CDIV - 10, 3 * CDIV + 6);
    // fine and coarse together: coarse runs out first
    put(5, `ACT_TIMER, 8'h83, 8'h06);
    put(6, `ACT_TIMER, 8'h8A, 8'hFF);
    go(8'h05);
    expire(10, 2 * CDIV - 10, 3 * CDIV + 6);
    go(8'h06);
    expire(10, 2 * CDIV - 10, 3 * CDIV + 6);
    expire(3, 800, 2100);
    $display("test timers done");
    results();
  end
endmodule

// ### dv/trigger_source.sv
// stand-in for the event rule engine that launches action chains
`timescale 1ns/1ps
module trigger_source (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       fire,
  input  wire logic [7:0] fire_index,
  input  wire logic [1:0] lag,
  input  wire logic       trig_ready,
  output logic            trig_valid,
  output logic [7:0]      trig_index,
  output logic            accepted
);
  logic       pend_r;  // request waiting for its lag to run out
  logic [1:0] wait_r;  // lag cycles left
  logic [7:0] hold_r;  // index of the waiting request
  // request held until taken; a released index toggles every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_valid <= 1'b0;
      trig_index <= 8'hA5;
      accepted   <= 1'b0;
      pend_r     <= 1'b0;
      wait_r     <= 2'h0;
      hold_r     <= 8'h00;
    end else begin
      accepted <= 1'b0;
      if (trig_valid && trig_ready) begin
        trig_valid <= 1'b0;
        trig_index <= ~trig_index;
        accepted   <= 1'b1;
      end else if (pend_r && wait_r == 2'h0) begin
        trig_valid <= 1'b1;
        trig_index <= hold_r;
        pend_r     <= 1'b0;
      end else if (!trig_valid) begin
        trig_index <= ~trig_index;
        if (pend_r) begin
          wait_r <= wait_r - 2'h1;
        end else if (fire) begin
          pend_r <= 1'b1;
          wait_r <= lag;
          hold_r <= fire_index;
        end
      end
    end
  end
endmodule

// ### logic/rule_action_executor.sv
// action rule executor with AHB-Lite register and rule table access
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rae_map.svh"
module rule_action_executor
  import rae_pkg::*;
#(
  parameter int DEPTH      = 64,
  parameter int TW         = 16,
  parameter int COARSE_DIV = `COARSE_TICK_NS / `CLK_PERIOD_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        trig_valid,
  input  wire logic [7:0]  trig_index,
  output logic             trig_ready,
  output logic [7:0]       pwm_duty_setting,
  output logic [7:0]       var1_value,
  output logic [7:0]       var2_value,
  output logic [11:0]      timer_running,
  output logic [11:0]      timer_expired
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [8:0] DEPTH9 = 9'(DEPTH);
  localparam int FINE_DIV = `FINE_TICK_NS / `CLK_PERIOD_NS;

  // ***************************************
  // declarations
  // ***************************************
  action_rule_t tbl_r [DEPTH];      // action rule table
  bus_req_t     req_r, req_nxt;     // latched address phase
  logic [31:0]  rdata_r, rdata_nxt; // read data register
  logic         normal_r, normal_nxt;       // normal mode
  logic [TW-1:0] fine_len_r, fine_len_nxt;  // fine preset
  logic [TW-1:0] coarse_len_r, coarse_len_nxt; // coarse preset
  exec_state_t  st_r, st_nxt;       // chain walker state
  logic [7:0]   idx_r, idx_nxt;     // rule being executed
  work_regs_t   wr_r, wr_nxt;       // var1, var2, duty
  work_regs_t   alu_out;            // change-variable result
  logic         ready_r, ready_nxt; // accepts a trigger
  action_rule_t cur;                // current rule
  logic         ap_take;            // address phase accepted
  logic         tbl_we;             // table write strobe
  logic [AW-1:0] tbl_widx;          // table write index
  logic [11:0]  tmr_start_c, tmr_cancel_c; // timer strobes
  logic [11:0]  run_w, exp_w;       // timer outputs
  logic         tmr_ok;             // timer code valid
  logic [31:0]  fdiv_r, fdiv_nxt, cdiv_r, cdiv_nxt; // dividers
  logic         ftick_r, ftick_nxt, ctick_r, ctick_nxt; // ticks

  // in-range test for a table index
  function automatic logic in_tbl(input logic [11:0] a);
    in_tbl = (a[11:10] == `TABLE_REGION) &&
             ({1'b0, a[9:2]} < DEPTH9);
  endfunction

  // ***************************************
  // bus slave: next values
  // ***************************************
  assign ap_take  = hsel && htrans[1] && hready;
  assign tbl_we   = req_r.valid && req_r.write && in_tbl(req_r.addr);
  assign tbl_widx = req_r.addr[AW+1:2];

  always_comb begin
    req_nxt        = '0;
    rdata_nxt      = rdata_r;
    normal_nxt     = normal_r;
    fine_len_nxt   = fine_len_r;
    coarse_len_nxt = coarse_len_r;
    // address phase: latch and prepare read data
    if (ap_take) begin
      req_nxt = '{valid: 1'b1, write: hwrite, addr: haddr[11:0]};
      rdata_nxt = 32'h00000000;
      if (!hwrite) begin
        if (in_tbl(haddr[11:0])) begin
          rdata_nxt = {8'h00, tbl_r[haddr[AW+1:2]]};
        end else begin
          unique case (haddr[11:0])
            `OFF_CTRL:       rdata_nxt[`CTRL_NORMAL_BIT] = normal_r;
            `OFF_STATUS: begin
              rdata_nxt[`STAT_BUSY_BIT] = (st_r == ST_RUN);
              rdata_nxt[`STAT_TMR_LSB +: `NUM_TIMERS] = run_w;
            end
            `OFF_VARS:       rdata_nxt[23:0] = wr_r;
            `OFF_FINE_LEN:   rdata_nxt[TW-1:0] = fine_len_r;
            `OFF_COARSE_LEN: rdata_nxt[TW-1:0] = coarse_len_r;
            default:         rdata_nxt = 32'h00000000;
          endcase
        end
      end
    end
    // data phase: register writes
    if (req_r.valid && req_r.write) begin
      unique case (req_r.addr)
        `OFF_CTRL:       normal_nxt = hwdata[`CTRL_NORMAL_BIT];
        `OFF_FINE_LEN:   fine_len_nxt = hwdata[TW-1:0];
        `OFF_COARSE_LEN: coarse_len_nxt = hwdata[TW-1:0];
        default:         normal_nxt = normal_r;
      endcase
    end
  end

  // ***************************************
  // bus slave and table registers
  // ***************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r        <= '0;
      rdata_r      <= 32'h00000000;
      normal_r     <= `RST_NORMAL;
      fine_len_r   <= `RST_FINE_LEN;
      coarse_len_r <= `RST_COARSE_LEN;
      for (int i = 0; i < DEPTH; i++) begin
        tbl_r[i] <= '{kind: 8'h00, param: 8'h00, next: `VOID_IDX};
      end
    end else begin
      req_r        <= req_nxt;
      rdata_r      <= rdata_nxt;
      normal_r     <= normal_nxt;
      fine_len_r   <= fine_len_nxt;
      coarse_len_r <= coarse_len_nxt;
      if (tbl_we) begin
        tbl_r[tbl_widx] <= hwdata[23:0];
      end
    end
  end

  assign hreadyout = 1'b1; // zero wait states
  assign hrdata    = rdata_r;
  assign hresp     = `BUS_OKAY;

  // ***************************************
  // tick dividers for the two timer groups
  // ***************************************
  always_comb begin
    ftick_nxt = (fdiv_r == 32'(FINE_DIV - 1));
    fdiv_nxt  = ftick_nxt ? 32'h00000000 : fdiv_r + 32'h00000001;
    ctick_nxt = (cdiv_r == 32'(COARSE_DIV - 1));
    cdiv_nxt  = ctick_nxt ? 32'h00000000 : cdiv_r + 32'h00000001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fdiv_r  <= 32'h00000000;
      cdiv_r  <= 32'h00000000;
      ftick_r <= 1'b0;
      ctick_r <= 1'b0;
    end else begin
      fdiv_r  <= fdiv_nxt;
      cdiv_r  <= cdiv_nxt;
      ftick_r <= ftick_nxt;
      ctick_r <= ctick_nxt;
    end
  end

  // ***************************************
  // chain walker and action decode
  // ***************************************
  assign cur    = tbl_r[idx_r[AW-1:0]];
  // bits 6..4 reserved, number 0..11 only
  assign tmr_ok = (cur.param[6:4] == 3'h0) &&
                  (cur.param[3:0] < 4'(`NUM_TIMERS));

  var_alu u_alu (
    .op  (cur.param),
    .cur (wr_r),
    .nxt (alu_out)
  );

  always_comb begin
    st_nxt       = st_r;
    idx_nxt      = idx_r;
    wr_nxt       = wr_r;
    ready_nxt    = ready_r;
    tmr_start_c  = 12'h000;
    tmr_cancel_c = 12'h000;
    unique case (st_r)
      ST_IDLE: begin
        // take a trigger; a void start index runs nothing
        if (trig_valid && ready_r) begin
          idx_nxt = trig_index;
          if (trig_index != `VOID_IDX && {1'b0, trig_index} < DEPTH9) begin
            st_nxt    = ST_RUN;
            ready_nxt = 1'b0;
          end
        end
      end
      ST_RUN: begin
        unique case (cur.kind)
          `ACT_SET_DUTY: begin
            if (normal_r) begin
              wr_nxt.duty = cur.param;
            end
          end
          `ACT_TIMER: begin
            if (tmr_ok) begin
              if (cur.param[`TMR_OP_BIT]) begin
                tmr_start_c[cur.param[3:0]] = 1'b1;
              end else begin
                tmr_cancel_c[cur.param[3:0]] = 1'b1;
              end
            end
          end
          `ACT_SET_V1: wr_nxt.var1 = cur.param;
          `ACT_SET_V2: wr_nxt.var2 = cur.param;
          `ACT_CHANGE: wr_nxt = alu_out;
          default:     wr_nxt = wr_r;
        endcase
        // every action, done or inhibited, moves on
        idx_nxt = cur.next;
        if (cur.next == `VOID_IDX || {1'b0, cur.next} >= DEPTH9) begin
          st_nxt    = ST_IDLE;
          ready_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r    <= ST_IDLE;
      idx_r   <= `VOID_IDX;
      wr_r    <= '0;
      ready_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      wr_r    <= wr_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign trig_ready       = ready_r;
  assign pwm_duty_setting = wr_r.duty;
  assign var1_value       = wr_r.var1;
  assign var2_value       = wr_r.var2;
  assign timer_running    = run_w;
  assign timer_expired    = exp_w;

  // ***************************************
  // rule timers: fine group then coarse group
  // ***************************************
  for (genvar t = 0; t < `NUM_TIMERS; t++) begin : g_tmr
    rule_timer #(.W(TW)) u_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    ((t < `NUM_FINE) ? ftick_r : ctick_r),
      .start   (tmr_start_c[t]),
      .cancel  (tmr_cancel_c[t]),
      .preset  ((t < `NUM_FINE) ? fine_len_r : coarse_len_r),
      .running (run_w[t]),
      .expired (exp_w[t])
    );
  end

  // ***************************************
  // assertions and covers
  // ***************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic run_duty, run_v1, run_chg;
  assign run_duty = st_r == ST_RUN && cur.kind == `ACT_SET_DUTY;
  assign run_v1   = st_r == ST_RUN && cur.kind == `ACT_SET_V1;
  assign run_chg  = st_r == ST_RUN && cur.kind == `ACT_CHANGE;

  duty_load_a: assert property (run_duty && normal_r |=>
    pwm_duty_setting == $past(cur.param)) else $error("duty not loaded");
  duty_inhibit_a: assert property (run_duty && !normal_r |=>
    $stable(pwm_duty_setting)) else $error("duty changed off mode");
  timer_start_a: assert property (tmr_start_c != 12'h000 |=>
    (timer_running & $past(tmr_start_c)) == $past(tmr_start_c))
    else $error("timer did not start");
  timer_cancel_a: assert property (tmr_cancel_c != 12'h000 |=>
    (timer_running & $past(tmr_cancel_c)) == 12'h000)
    else $error("timer still running after cancel");
  timer_rsvd_a: assert property (st_r == ST_RUN &&
    cur.kind == `ACT_TIMER && !tmr_ok |->
    tmr_start_c == 12'h000 && tmr_cancel_c == 12'h000)
    else $error("reserved timer code acted");
  set_var1_a: assert property (run_v1 |=>
    var1_value == $past(cur.param)) else $error("var1 not loaded");
  dec_wrap_a: assert property (run_chg && cur.param == `CV_DEC_V1 &&
    var1_value == 8'h00 |=> var1_value == 8'hFF)
    else $error("var1 decrement did not wrap");
  shift_left_a: assert property (run_chg && cur.param == `CV_SHL_V1 |=>
    var1_value == {$past(var1_value[6:0]), 1'b0})
    else $error("var1 shift left wrong");
  chain_end_a: assert property (st_r == ST_RUN &&
    cur.next == `VOID_IDX |=> st_r == ST_IDLE && trig_ready)
    else $error("chain did not end");

  chain_two_c: cover property (st_r == ST_RUN ##1 st_r == ST_RUN);
  timer_expire_c: cover property (timer_expired != 12'h000);
  duty_set_c: cover property (run_duty && normal_r);

endmodule

// ### logic/rule_timer.sv
// one-shot rule timer counting enable ticks
`timescale 1ns/1ps
module rule_timer #(
  parameter int W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic         cancel,
  input  wire logic [W-1:0] preset,
  output logic              running,
  output logic              expired
);

  logic [W-1:0] cnt_r, cnt_nxt;  // ticks left
  logic         run_r, run_nxt;  // interval in progress
  logic         exp_r, exp_nxt;  // expiry pulse

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (cancel) begin
      // cancelled: interval zeroed, reads stopped
      cnt_nxt = '0;
      run_nxt = 1'b0;
    end else if (start) begin
      // a zero preset still runs for one tick
      cnt_nxt = (preset == '0) ? W'(1) : preset;
      run_nxt = 1'b1;
    end else if (run_r && tick) begin
      if (cnt_r <= W'(1)) begin
        // stops by itself, never reloads
        cnt_nxt = '0;
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  // ***************************************
  // registers; stopped after reset
  // ***************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign running = run_r;
  assign expired = exp_r;

endmodule

// ### logic/var_alu.sv
// change-variable arithmetic on the working bytes
`timescale 1ns/1ps
module var_alu
  import rae_pkg::*;
(
  input  wire logic [7:0] op,
  input  work_regs_t      cur,
  output work_regs_t      nxt
);
`include "rae_map.svh"

  // ***************************************
  // operation select; unknown codes leave all alone
  // ***************************************
  always_comb begin
    nxt = cur;
    unique case (op)
      `CV_DEC_V1:   nxt.var1 = cur.var1 - 8'h01;
      `CV_INC_V1:   nxt.var1 = cur.var1 + 8'h01;
      `CV_SHR_V1:   nxt.var1 = {1'b0, cur.var1[7:1]};
      `CV_SHL_V1:   nxt.var1 = {cur.var1[6:0], 1'b0};
      `CV_DEC_V2:   nxt.var2 = cur.var2 - 8'h01;
      `CV_INC_V2:   nxt.var2 = cur.var2 + 8'h01;
      `CV_SHR_V2:   nxt.var2 = {1'b0, cur.var2[7:1]};
      `CV_SHL_V2:   nxt.var2 = {cur.var2[6:0], 1'b0};
      `CV_DEC_DUTY: nxt.duty = cur.duty - 8'h01;
      `CV_INC_DUTY: nxt.duty = cur.duty + 8'h01;
      `CV_SHR_DUTY: nxt.duty = {1'b0, cur.duty[7:1]};
      `CV_SHL_DUTY: nxt.duty = {cur.duty[6:0], 1'b0};
      `CV_V2_TO_V1: nxt.var1 = cur.var2;
      `CV_V1_TO_V2: nxt.var2 = cur.var1;
      `CV_DUTY_V1:  nxt.var1 = cur.duty;
      `CV_V1_DUTY:  nxt.duty = cur.var1;
      `CV_ADD:      nxt.var1 = cur.var1 + cur.var2;
      `CV_SUB:      nxt.var1 = cur.var1 - cur.var2;
      default:      nxt = cur;
    endcase
  end

endmodule

// ### shared/rae_map.svh
// address map, field positions, reset values, codes and timing constants
`ifndef RAE_MAP_SVH
`define RAE_MAP_SVH

// ***************************************
// register offsets (byte addresses)
// ***************************************
`define OFF_CTRL       12'h000
`define OFF_STATUS     12'h004
`define OFF_VARS       12'h008
`define OFF_FINE_LEN   12'h00C
`define OFF_COARSE_LEN 12'h010
`define TABLE_REGION   2'h1
`define BUS_OKAY       1'h0

// ***************************************
// field positions and reset values
// ***************************************
`define CTRL_NORMAL_BIT 0
`define STAT_BUSY_BIT   0
`define STAT_TMR_LSB    16
`define RST_NORMAL      1'h1
`define RST_FINE_LEN    16'h000A
`define RST_COARSE_LEN  16'h000A

// ***************************************
// action types, timer fields, chain end
// ***************************************
`define ACT_SET_DUTY 8'h66
`define ACT_TIMER    8'h67
`define ACT_SET_V1   8'h68
`define ACT_SET_V2   8'h69
`define ACT_CHANGE   8'h6A
`define TMR_OP_BIT   7
`define VOID_IDX     8'hFF
`define NUM_TIMERS   12
`define NUM_FINE     8

// ***************************************
// change-variable operation codes
// ***************************************
`define CV_DEC_V1   8'h00
`define CV_INC_V1   8'h01
`define CV_SHR_V1   8'h02
`define CV_SHL_V1   8'h03
`define CV_DEC_V2   8'h04
`define CV_INC_V2   8'h05
`define CV_SHR_V2   8'h06
`define CV_SHL_V2   8'h07
`define CV_DEC_DUTY 8'h08
`define CV_INC_DUTY 8'h09
`define CV_SHR_DUTY 8'h0A
`define CV_SHL_DUTY 8'h0B
`define CV_V2_TO_V1 8'h0C
`define CV_V1_TO_V2 8'h0D
`define CV_DUTY_V1  8'h0E
`define CV_V1_DUTY  8'h0F
`define CV_ADD      8'h10
`define CV_SUB      8'h11

// ***************************************
// timing: clock period and timer tick periods in ns
// ***************************************
`define CLK_PERIOD_NS  100
`define FINE_TICK_NS   100000
`define COARSE_TICK_NS 10000000

`endif

// ### shared/rae_pkg.sv
// types shared by the rule action executor design files
package rae_pkg;

  // one action rule as stored in the table
  typedef struct packed {
    logic [7:0] kind;   // action type
    logic [7:0] param;  // action specific byte
    logic [7:0] next;   // next rule in the chain
  } action_rule_t;

  // the three working bytes the actions act on
  typedef struct packed {
    logic [7:0] var1;
    logic [7:0] var2;
    logic [7:0] duty;
  } work_regs_t;

  // latched bus address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } bus_req_t;

  // chain walker states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } exec_state_t;

endpackage
